// file: core/dpl_pkg.sv
// Constants, types and helpers for the dual pixel serial link transmitter.
// Assumes a 100 MHz register clock and a serial slot clock of 7x pixel rate.
//
// What this block does
// [R01] Forwarded link clock is high four slots, then low three slots.
// [R02] Link clock rises two slots before the first data slot of a pixel.
// [R03] Bit 17 of each pixel fills two consecutive slots on its pair.
// [R04] Data enable is carried in two slots of every clock period.
// [R05] Both link clock outputs carry the same waveform outside single mode.
// [R06] Two reserved slots carry no content; receiver leaves their outputs open.
// [R07] Pixel data sampled on rising strobe edge if strobe_edge_select high, else falling.
// [R08] enable_polarity_select high: enable high is active; low: enable low is active.
// [R09] Dual mode: two pixels per clock, both links and both clocks driven.
// [R10] Single mode: one pixel per clock, second link pairs and clock disabled.
// [R11] Split mode: odd pixels to first link, even pixels to second link.
// [R12] Split pairing restarts on enable going active; first pixel is odd.
// [R13] In split mode the source keeps enable_polarity_select high.
// [R14] In split mode the source makes every blanking interval an even length.
// [R15] power_on_control low: PLL stopped, all serial outputs not driven.
// [R16] Software keeps power_on_control low until the supply is stable.
// [R17] Outputs are invalid until the PLL settle time passes after power-up.
// [R18] Each pair shifts seven bits per pixel period, aligned to the link clock.
package dpl_pkg;

  // ----------------------------------------------------------------------
  // Frame layout and slot timing
  // ----------------------------------------------------------------------
  localparam int unsigned PIX_W = 23;
  localparam int unsigned FRAME_W = 28;
  localparam int unsigned PAIRS = 4;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam logic [2:0] CLK_RISE_SLOT = 3'h5;
  localparam logic [2:0] CLK_FALL_SLOT = 3'h2;

  // ----------------------------------------------------------------------
  // PLL settle time
  // ----------------------------------------------------------------------
  localparam int unsigned PLL_SETTLE_MS = 10;
  localparam int unsigned MCLK_MHZ = 100;
  localparam int unsigned PLL_SETTLE_CYC = PLL_SETTLE_MS * 1000 * MCLK_MHZ;
  localparam int unsigned SETTLE_W = 20;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int unsigned STAT_SETTLED = 0;
  localparam int unsigned STAT_PHASE = 1;
  localparam int unsigned STAT_OVF = 2;
  localparam int unsigned STAT_PWR = 3;

  typedef enum logic [1:0] {
    DPL_SINGLE = 2'h0,
    DPL_SPLIT = 2'h1,
    DPL_DUAL = 2'h2
  } dpl_mode_t;

  typedef struct packed {
    logic [1:0] lane_mode;
    logic enable_polarity_select;
    logic strobe_edge_select;
    logic power_on_control;
  } dpl_ctrl_t;

  typedef struct packed {
    logic clk;
    logic de;
    logic [PIX_W-1:0] b;
    logic [PIX_W-1:0] a;
  } dpl_pix_t;

  typedef struct packed {
    logic first_link_clock;
    logic second_link_clock;
    logic [PAIRS-1:0] d1;
    logic [PAIRS-1:0] d0;
  } dpl_link_t;

  // Bit 17 doubled, enable doubled, two reserved zero slots
  function automatic logic [FRAME_W-1:0] dpl_frame(input logic [PIX_W-1:0] pix,
                                                   input logic act);
    dpl_frame = {2'h0, act, act, pix[22:18], pix[17], pix[17:0]};
  endfunction

  // Bit of every pair for one slot
  function automatic logic [PAIRS-1:0] dpl_pick(input logic [FRAME_W-1:0] f,
                                                input logic [2:0] slot);
    logic [PAIRS-1:0] v;
    v = '0;
    for (int p = 0; p < PAIRS; p++) begin
      v[p] = f[7*p + slot];
    end
    return v;
  endfunction

endpackage

// file: core/dpl_serializer.sv
// Pixel capture, mode logic, APB registers and serial slot sequencer.
// Assumes pixel pins are asynchronous to mclk and ser_clk runs at 7x pixel rate.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module dpl_serializer #(
  parameter int unsigned SETTLE_CYC = dpl_pkg::PLL_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ser_clk,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dpl_pkg::dpl_pix_t pix_in,
  output dpl_pkg::dpl_link_t link_out,
  output logic [1:0] link_oe_n
);
  import dpl_pkg::*;

  // ----------------------------------------------------------------------
  // Register clock domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    dpl_pix_t p1;
    dpl_pix_t p2;
    logic clk_prev;
    logic act_prev;
    logic phase_even;
    logic [FRAME_W-1:0] hold;
    logic [FRAME_W-1:0] tx0;
    logic [FRAME_W-1:0] tx1;
    logic req;
    logic ack1;
    logic ack2;
    logic [SETTLE_W-1:0] settle;
    logic settled;
    logic ovf;
    dpl_ctrl_t ctrl;
    logic [31:0] rdata;
  } dpl_mstate_t;

  // ----------------------------------------------------------------------
  // Link clock domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic r1;
    logic r2;
    logic seen;
    logic pw1;
    logic pw2;
    logic [1:0] m1;
    logic [1:0] m2;
    logic [1:0] m3;
    logic [1:0] mm;
    logic [2:0] slot;
    logic [FRAME_W-1:0] cur0;
    logic [FRAME_W-1:0] cur1;
    dpl_link_t out;
    logic [1:0] oe_n;
  } dpl_lstate_t;

  dpl_mstate_t s;
  dpl_mstate_t next_s;
  dpl_lstate_t l;
  dpl_lstate_t next_l;

  logic strobe;
  logic act;
  logic busy;
  logic act_rise;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  dpl_mode_t mode;
  dpl_mode_t lmode;

  // Decode helpers on settled pin copies
  assign strobe = s.ctrl.strobe_edge_select ? (s.p2.clk & ~s.clk_prev)
                                             : (~s.p2.clk & s.clk_prev); // [R07]
  assign act = s.ctrl.enable_polarity_select ? s.p2.de : ~s.p2.de; // [R08]
  assign act_rise = act & ~s.act_prev;
  assign busy = s.req ^ s.ack2;
  assign mode = dpl_mode_t'(s.ctrl.lane_mode);
  assign lmode = dpl_mode_t'(l.mm);

  // APB decode, zero wait states
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.rdata;

  // ----------------------------------------------------------------------
  // Register domain next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic send;
    logic [FRAME_W-1:0] w0;
    logic [FRAME_W-1:0] w1;
    send = 1'b0;
    w0 = s.tx0;
    w1 = s.tx1;
    next_s = s;
    // Pins through two flops, third copy for edge detect
    next_s.p1 = pix_in;
    next_s.p2 = s.p1;
    next_s.clk_prev = s.p2.clk;
    next_s.ack1 = l.seen;
    next_s.ack2 = s.ack1;
    // PLL settle count restarts on every power-down
    if (!s.ctrl.power_on_control) begin
      next_s.settle = '0;
      next_s.settled = 1'b0; // [R15]
    end else if (s.settle == SETTLE_CYC[SETTLE_W-1:0]) begin
      next_s.settled = 1'b1; // [R17]
    end else begin
      next_s.settle = s.settle + 1'b1;
    end
    // Overflow flag clear by writing one
    if (wr_en && mapped && paddr == ADDR_STAT && pstrb[0] && pwdata[STAT_OVF]) begin
      next_s.ovf = 1'b0;
    end
    // Pixel capture on the selected strobe edge
    if (strobe && s.ctrl.power_on_control) begin
      next_s.act_prev = act;
      case (mode)
        DPL_SPLIT: begin
          if (s.phase_even && !act_rise) begin
            w0 = s.hold; // [R11]
            w1 = dpl_frame(s.p2.a, act);
            send = 1'b1;
            next_s.phase_even = 1'b0;
          end else begin
            next_s.hold = dpl_frame(s.p2.a, act); // [R12]
            next_s.phase_even = 1'b1;
          end
        end
        DPL_SINGLE: begin
          w0 = dpl_frame(s.p2.a, act); // [R10]
          w1 = '0;
          send = 1'b1;
          next_s.phase_even = 1'b0;
        end
        default: begin
          w0 = dpl_frame(s.p2.a, act); // [R09]
          w1 = dpl_frame(s.p2.b, act);
          send = 1'b1;
          next_s.phase_even = 1'b0;
        end
      endcase
    end
    // Hand a frame pair to the link side; set wins over clear
    if (send) begin
      if (busy) begin
        next_s.ovf = 1'b1;
      end else begin
        next_s.tx0 = w0;
        next_s.tx1 = w1;
        next_s.req = ~s.req;
      end
    end
    // Register writes
    if (wr_en && paddr == ADDR_CTRL && pstrb[0]) begin
      next_s.ctrl = dpl_ctrl_t'(pwdata[4:0]);
    end
    // Read data latched in the setup phase
    if (rd_setup) begin
      next_s.rdata = 32'h0;
      if (paddr == ADDR_CTRL) begin
        next_s.rdata[4:0] = s.ctrl;
      end else if (paddr == ADDR_STAT) begin
        next_s.rdata[STAT_SETTLED] = s.settled;
        next_s.rdata[STAT_PHASE] = s.phase_even;
        next_s.rdata[STAT_OVF] = s.ovf;
        next_s.rdata[STAT_PWR] = s.ctrl.power_on_control;
      end
    end
  end

  // Register domain flops; reset leaves the part powered down
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.ctrl <= dpl_ctrl_t'(CTRL_RESET); // [R16]
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_l = l;
    next_l.r1 = s.req;
    next_l.r2 = l.r1;
    next_l.pw1 = s.ctrl.power_on_control;
    next_l.pw2 = l.pw1;
    next_l.m1 = s.ctrl.lane_mode;
    next_l.m2 = l.m1;
    // Lane mode taken only once two synced samples agree; hides split bits
    next_l.m3 = l.m2;
    if (l.m2 == l.m3) begin
      next_l.mm = l.m3;
    end
    // Seven slots per pixel period
    next_l.slot = (l.slot == SLOT_LAST) ? 3'h0 : l.slot + 3'h1; // [R18]
    // New frame pair taken only at a period boundary
    if (next_l.slot == 3'h0 && l.r2 != l.seen) begin
      next_l.seen = l.r2;
      next_l.cur0 = s.tx0;
      next_l.cur1 = s.tx1;
    end
    // Clock high slots 5,6,0,1; low slots 2,3,4
    next_l.out.first_link_clock = (next_l.slot >= CLK_RISE_SLOT) ||
                                  (next_l.slot < CLK_FALL_SLOT); // [R01] [R02]
    next_l.out.second_link_clock = next_l.out.first_link_clock; // [R05]
    next_l.out.d0 = dpl_pick(next_l.cur0, next_l.slot); // [R03] [R04] [R06]
    next_l.out.d1 = dpl_pick(next_l.cur1, next_l.slot);
    next_l.oe_n = 2'b00;
    // Second link idle in single mode
    if (lmode == DPL_SINGLE) begin
      next_l.out.d1 = '0;
      next_l.out.second_link_clock = 1'b0;
      next_l.oe_n[1] = 1'b1; // [R10]
    end
    // Power-down releases every serial output
    if (!l.pw2) begin
      next_l.out = '0;
      next_l.oe_n = 2'b11; // [R15]
    end
  end

  // Link domain flops
  always_ff @(posedge ser_clk or negedge arst_n) begin
    if (!arst_n) begin
      l <= '0;
      l.oe_n <= 2'b11;
    end else begin
      l <= next_l;
    end
  end

  assign link_out = l.out;
  assign link_oe_n = l.oe_n;

  // ----------------------------------------------------------------------
  // Checks on the link side
  // ----------------------------------------------------------------------
  // Four high then three low, once outputs were live before the rise
  AST_CLK_SHAPE: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R01]
    ($rose(link_out.first_link_clock) && l.pw2 && $past(l.pw2, 2)) |->
      link_out.first_link_clock[*4] ##1 !link_out.first_link_clock[*3])
    else $error("link clock not four high three low");

  // Genuine rise leads the first data slot by two slots
  AST_CLK_LEAD: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R02]
    ($rose(link_out.first_link_clock) && $past(l.pw2, 2)) |-> ##2 (l.slot == 3'h0))
    else $error("link clock rise not two slots ahead of data");

  // Wide bit repeated in slots three and four
  AST_WIDE_BIT: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R03]
    (l.slot == 3'h3) |=> (link_out.d0[2] == $past(link_out.d0[2]) &&
                          link_out.d1[2] == $past(link_out.d1[2])))
    else $error("wide bit not held two slots");

  // Enable repeated in slots three and four of the last pair
  AST_ENABLE_TWO: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R04]
    (l.slot == 3'h3 && l.pw2 && !$past(l.pw2)) or
    ((l.slot == 3'h3) |=> (link_out.d0[3] == $past(link_out.d0[3]))))
    else $error("enable not carried in two slots");

  // Both clocks alike outside single mode while mode and power have been steady
  AST_CLK_TWIN: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R05]
    (lmode != DPL_SINGLE && $stable(lmode) && l.pw2 && $past(l.pw2)) |->
      (link_out.second_link_clock == link_out.first_link_clock))
    else $error("link clocks differ");

  // Reserved slots of the last pair stay low
  AST_RESERVED: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R06]
    (l.slot >= 3'h5) |-> (link_out.d0[3] == 1'b0 && link_out.d1[3] == 1'b0))
    else $error("reserved slot not zero");

  // Second link released in single mode
  AST_SINGLE_OFF: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R10]
    (lmode == DPL_SINGLE && $stable(lmode)) |=>
      (link_oe_n[1] && !link_out.second_link_clock && link_out.d1 == 4'h0))
    else $error("second link active in single mode");

  // Both links driven outside single mode when powered
  AST_SECOND_OE: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R09]
    (lmode != DPL_SINGLE && $stable(lmode) && l.pw2) |=> (link_oe_n == 2'b00))
    else $error("link not driven in two link mode");

  // Every output released in power-down
  AST_POWER_DOWN: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R15]
    (!l.pw2) |=> (link_oe_n == 2'b11))
    else $error("outputs driven while powered down");

  // Slot counter wraps after the last slot
  AST_SLOT_WRAP: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R18]
    (l.slot == SLOT_LAST) |=> (l.slot == 3'h0))
    else $error("slot counter did not wrap");

  // Slot counter steps by one inside a period
  AST_SLOT_STEP: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R18]
    (l.slot != SLOT_LAST) |=> (l.slot == $past(l.slot) + 3'h1))
    else $error("slot counter skipped");

  // Frames change only at a period boundary
  AST_FRAME_BOUNDARY: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R18]
    !$stable(l.cur0) |-> (l.slot == 3'h0))
    else $error("frame changed inside a period");

  // A pending frame pair is taken at the next boundary
  AST_FRAME_TAKE: assert property (@(posedge ser_clk) disable iff (!arst_n) // [R18]
    (l.slot == SLOT_LAST && l.r2 != l.seen) |=> (l.seen == $past(l.r2)))
    else $error("pending frame not taken at boundary");

  // ----------------------------------------------------------------------
  // Checks on the register side
  // ----------------------------------------------------------------------
  // Enable going active starts a new odd pixel
  AST_SPLIT_RESTART: assert property (@(posedge mclk) disable iff (!arst_n) // [R12]
    (strobe && s.ctrl.power_on_control && mode == DPL_SPLIT && act_rise) |=>
      (s.phase_even && s.hold == $past(dpl_frame(s.p2.a, act))))
    else $error("split pairing did not restart on odd pixel");

  // Held odd pixel goes out with the even one
  AST_SPLIT_PAIR: assert property (@(posedge mclk) disable iff (!arst_n) // [R11]
    (strobe && s.ctrl.power_on_control && mode == DPL_SPLIT && s.phase_even &&
     !act_rise && !busy) |=> (s.tx0 == $past(s.hold) && s.req != $past(s.req)))
    else $error("split pair not handed over");

  // Second pixel of a dual strobe feeds the second link
  AST_DUAL_SECOND: assert property (@(posedge mclk) disable iff (!arst_n) // [R09]
    (strobe && s.ctrl.power_on_control && mode == DPL_DUAL && !busy) |=>
      (s.tx1 == $past(dpl_frame(s.p2.b, act))))
    else $error("second pixel not sent in dual mode");

  // No capture while powered down
  AST_NO_CAPTURE_OFF: assert property (@(posedge mclk) disable iff (!arst_n) // [R15]
    (!s.ctrl.power_on_control) |=> (s.req == $past(s.req)))
    else $error("frame sent while powered down");

  // Settled only after the full count with power on
  AST_SETTLE: assert property (@(posedge mclk) disable iff (!arst_n) // [R17]
    $rose(s.settled) |->
      (s.settle == SETTLE_CYC[SETTLE_W-1:0] && $past(s.ctrl.power_on_control)))
    else $error("settled before settle count");

  // Power-down drops the settled flag
  AST_SETTLE_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n) // [R17]
    (!s.ctrl.power_on_control) |=> !s.settled)
    else $error("settled kept through power-down");

  // Capture only on the selected strobe edge
  AST_EDGE: assert property (@(posedge mclk) disable iff (!arst_n) // [R07]
    (strobe) |-> (s.p2.clk == s.ctrl.strobe_edge_select))
    else $error("capture on wrong strobe edge");

endmodule

// file: testbench/dpl_far_side.sv
// Far side models: pixel source (graphics controller) and link receiver.
// Assumes mclk at 100 MHz and link outputs registered on ser_clk.
module dpl_pix_src import dpl_pkg::*; #(
  parameter int unsigned HALF = 44
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic alt,
  input wire logic pol,
  input wire logic de_req,
  input wire logic [dpl_pkg::PIX_W-1:0] pa,
  input wire logic [dpl_pkg::PIX_W-1:0] pb,
  output dpl_pkg::dpl_pix_t pix
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  logic per;
  logic de_q;
  logic par;
  logic next_de;
  // --------------------------------------------------------------------
  // Pixel clock, enable and pixel order
  // --------------------------------------------------------------------
  // Enable moves only every second period, so blanking stays even
  assign next_de = per ? de_q : de_req;
  // Clock stands still while run is low; data moves mid-level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      per <= 1'b0;
      de_q <= 1'b0;
      par <= 1'b0;
    end else if (run) begin
      cnt <= (cnt == 8'(2 * HALF - 1)) ? 8'h00 : cnt + 8'h01;
      if (cnt == 8'(HALF / 2)) begin
        per <= ~per;
        de_q <= next_de;
        par <= (de_q && next_de) ? ~par : 1'b0;
      end
    end
  end
  // Rising edge sees pa, falling edge pb, unless pixels alternate
  always_comb begin
    pix.clk = (cnt < 8'(HALF));
    pix.de = pol ? de_q : ~de_q;
    pix.b = pb;
    if (alt) begin
      pix.a = par ? pb : pa;
    end else begin
      pix.a = (cnt >= 8'(HALF / 2) && cnt < 8'(HALF + HALF / 2)) ? pb : pa;
    end
  end
endmodule

module dpl_link_rx import dpl_pkg::*; (
  input wire logic ser_clk,
  input wire dpl_pkg::dpl_link_t link,
  output logic [dpl_pkg::FRAME_W-1:0] f0,
  output logic [dpl_pkg::FRAME_W-1:0] f1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] ck;
  logic [6:0] q0 [PAIRS];
  logic [6:0] q1 [PAIRS];
  // Frame taken only when clock shows high 4, low 3, rise two ahead
  always @(posedge ser_clk) begin
    ck <= {link.first_link_clock, ck[6:1]};
    for (int p = 0; p < PAIRS; p++) begin
      q0[p] <= {link.d0[p], q0[p][6:1]};
      q1[p] <= {link.d1[p], q1[p][6:1]};
      for (int s = 0; s < 7; s++) begin
        if (ck == 7'h63) begin
          f0[7 * p + s] <= q0[p][s];
          f1[7 * p + s] <= q1[p][s];
        end
      end
    end
  end
endmodule

// file: testbench/tb_dual_pixel_lvds_serializer.sv
// Self-checking bench for the pixel serial link transmitter.
// Assumes the far side models and the design package are compiled first.
module tb_dual_pixel_lvds_serializer import dpl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, arst_n, ser_clk, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  dpl_pix_t pix_in;
  dpl_link_t link_out;
  logic [1:0] link_oe_n;
  logic run, alt, pol, de_req, er;
  logic [PIX_W-1:0] pa, pb;
  logic [FRAME_W-1:0] f0, f1;
  int errors, samples_checked;
  dpl_serializer #(.SETTLE_CYC(50)) u_dut (.mclk(mclk), .arst_n(arst_n), .ser_clk(ser_clk),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
    .link_out(link_out), .link_oe_n(link_oe_n));
  dpl_pix_src u_src (.mclk(mclk), .arst_n(arst_n), .run(run), .alt(alt), .pol(pol),
    .de_req(de_req), .pa(pa), .pb(pb), .pix(pix_in));
  dpl_link_rx u_rx (.ser_clk(ser_clk), .link(link_out), .f0(f0), .f1(f1));
  // --------------------------------------------------------------------
  // Clocks
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    ser_clk = 1'b0;
    #3.3;
    forever #62.5 ser_clk = ~ser_clk;
  end
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  function automatic logic [27:0] frm(input logic [22:0] p, input logic act);
    return {2'h0, act, act, p[22:18], p[17], p[17:0]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    if (n == 20) begin
      chk(32'h0, 32'h1, "apb timeout");
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cfg(input logic [1:0] m, input logic p, input logic e, input logic on);
    pol <= p;
    apb(1'b1, ADDR_CTRL, {27'h0, m, p, e, on});
    repeat (700) @(posedge mclk);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, ADDR_CTRL, 32'h16);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h16, "ctrl readback");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped error");
    $display("test regs done");
  endtask
  task automatic t_power();
    int n;
    cfg(DPL_SINGLE, 1'b1, 1'b1, 1'b0);
    chk(link_oe_n, 2'h3, "oe in power down");
    chk(link_out, 32'h0, "link in power down");
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd[STAT_SETTLED], 32'h0, "settled too soon");
    n = 0;
    while (rd[STAT_SETTLED] !== 1'b1 && n < 100) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      n++;
    end
    chk(rd[STAT_SETTLED], 32'h1, "settled flag");
    $display("test power done");
  endtask
  task automatic t_dual();
    cfg(DPL_DUAL, 1'b1, 1'b1, 1'b1);
    chk(f0, frm(pa, 1'b1), "dual first link");
    chk(f1, frm(pb, 1'b1), "dual second link");
    chk(link_oe_n, 32'h0, "dual enables");
    repeat (7) begin
      @(negedge ser_clk);
      chk(link_out.second_link_clock, link_out.first_link_clock, "clock copy");
    end
    $display("test dual done");
  endtask
  task automatic t_single();
    cfg(DPL_SINGLE, 1'b1, 1'b1, 1'b1);
    chk(link_oe_n, 32'h2, "single enables");
    chk(f0, frm(pa, 1'b1), "single rising strobe");
    repeat (7) begin
      @(negedge ser_clk);
      chk({link_out.second_link_clock, link_out.d1}, 32'h0, "second link idle");
    end
    cfg(DPL_SINGLE, 1'b1, 1'b0, 1'b1);
    chk(f0, frm(pb, 1'b1), "falling strobe");
    $display("test single done");
  endtask
  task automatic t_pol();
    cfg(DPL_SINGLE, 1'b0, 1'b1, 1'b1);
    chk(f0, frm(pa, 1'b1), "low enable active");
    de_req <= 1'b0;
    repeat (700) @(posedge mclk);
    chk(f0, frm(pa, 1'b0), "low enable blank");
    cfg(DPL_SINGLE, 1'b1, 1'b1, 1'b1);
    chk(f0, frm(pa, 1'b0), "high enable blank");
    $display("test polarity done");
  endtask
  task automatic t_split(input logic [22:0] x, input logic [22:0] y);
    de_req <= 1'b0;
    alt <= 1'b1;
    pa <= x;
    pb <= y;
    cfg(DPL_SPLIT, 1'b1, 1'b1, 1'b1);
    de_req <= 1'b1;
    repeat (1000) @(posedge mclk);
    chk(f0, frm(x, 1'b1), "split odd pixel");
    chk(f1, frm(y, 1'b1), "split even pixel");
    $display("test split done");
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {run, alt, pol, de_req} = 4'h3;
    pa = 23'h123456;
    pb = 23'h4dcba9;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    run <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_power();
    t_dual();
    t_single();
    t_pol();
    t_split(23'h123456, 23'h4dcba9);
    t_split(23'h0a5f30, 23'h7e0c11);
    print_verdict();
  end
endmodule
